// ---- logic/dmcg_pkg.sv ----
// Package: register map, field layout and command types for the gating-bank host controller
package dmcg_pkg;

	// ==========================================================
	// Register addresses (device register space)
	localparam logic [15:0] ADDR_OUT_DIV2_AUTO  = 16'h0a20;
	localparam logic [15:0] ADDR_OUT_DIV3_AUTO  = 16'h0a26;
	localparam logic [15:0] ADDR_OUT_DIV4_AUTO  = 16'h0a2c;
	localparam logic [15:0] ADDR_RSVD_UPD_A     = 16'h0b24;
	localparam logic [15:0] ADDR_RSVD_UPD_B     = 16'h0b25;
	localparam logic [15:0] ADDR_FRAC_GATE      = 16'h0b44;
	localparam logic [15:0] ADDR_LOCKMON_GATE   = 16'h0b45;
	localparam logic [15:0] ADDR_ABSENCE_GATE   = 16'h0b46;
	localparam logic [15:0] ADDR_OFFSET_CLK     = 16'h0b47;
	localparam logic [15:0] ADDR_OFFSET_DIV     = 16'h0b48;
	localparam logic [15:0] ADDR_CALIB_OVR      = 16'h0b49;
	localparam logic [15:0] ADDR_DIV_CLK_GATE   = 16'h0b4a;
	localparam logic [15:0] ADDR_VCO_CODE_LO    = 16'h0b57;
	localparam logic [15:0] ADDR_VCO_CODE_HI    = 16'h0b58;

	// ==========================================================
	// Field positions
	localparam int AUTOSTOP_BIT      = 3;
	localparam int FB_FRAC_A_BIT     = 4;
	localparam int FB_FRAC_B_BIT     = 5;
	localparam int REFOSC_BIT        = 4;
	localparam int OUT_GATE_MSB_BIT  = 4;
	localparam int FB_DIV_GATE_BIT   = 5;
	localparam int FB_CAL_INH_BIT    = 6;

	// ==========================================================
	// Masks of the field bits within each register
	localparam logic [7:0] MASK_LOW4     = 8'h0f;
	localparam logic [7:0] MASK_FRAC_ALL = 8'h3f;
	localparam logic [7:0] MASK_LOCKMON  = 8'h03;
	localparam logic [7:0] MASK_OFFSET   = 8'h13;
	localparam logic [7:0] MASK_CALIB    = 8'h0f;
	localparam logic [7:0] MASK_DIVGATE  = 8'h7f;
	localparam logic [7:0] MASK_AUTOSTOP = 8'h08;
	localparam logic [7:0] MASK_HI_CODE  = 8'h0f;

	// ==========================================================
	// Command opcodes and bus record
	typedef enum logic [2:0] {
		DMCG_OP_RAW      = 3'h0,
		DMCG_OP_NORMAL   = 3'h1,
		DMCG_OP_FRAC     = 3'h2,
		DMCG_OP_OUTLOOPS = 3'h3,
		DMCG_OP_VCOCODE  = 3'h4,
		DMCG_OP_UPDATE   = 3'h5,
		DMCG_OP_AUTOSTOP = 3'h6
	} dmcg_op_t;

	typedef struct packed {
		dmcg_op_t    op;
		logic [15:0] addr;
		logic [11:0] data;
	} dmcg_cmd_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} dmcg_reg_req_t;

endpackage

// ---- logic/dmcg_host.sv ----
// Host controller that programs the divider and monitor clock gating registers
`timescale 1ns/10ps

// Notes on behaviour
// [RULE_01] Outputs two, three and four each own a load autostop bit at position 3 of own register.
// [RULE_02] Bits 3:0 of the fractional gate register gate input dividers 3..0; one stops the clock.
// [RULE_03] An input divider with a fractional ratio must have its fractional gate bit written zero.
// [RULE_04] Bit 4 gates loop A feedback fraction and must be zero when that ratio is fractional.
// [RULE_05] Bit 5 gates loop B feedback fraction and must be zero when that ratio is fractional.
// [RULE_06] Lock-fail monitor gate bits 0 and 1 must be zero for lock-fail detection.
// [RULE_07] Input absence gate bits 3:0 must be zero for each input's absence detection.
// [RULE_08] Offset monitor clock gate bits 1:0 and 4 must be zero in normal operation.
// [RULE_09] Offset monitor divider gate bits 1:0 and 4 must be zero in normal operation.
// [RULE_10] Calibration inhibit bits 1:0 and force bits 3:2 stay zero in normal operation.
// [RULE_11] Output divider gate bit 4 is always one and bits 3:0 are cleared for used loops.
// [RULE_12] Feedback divider gate bit 5 is written zero to run the feedback divider.
// [RULE_13] Feedback calibration inhibit bit 6 is written zero to permit calibration.
// [RULE_14] The twelve-bit oscillator reset code is split low byte then low nibble of next.
// [RULE_15] Both reserved update registers are written during an in-service update procedure.
// [RULE_16] Each read-write field reads back its last written value and acts at once.
module dmcg_host
	import dmcg_pkg::*;
#(
	parameter int NUM_NORMAL = 9
)(
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    cmd_valid,
	input  dmcg_pkg::dmcg_cmd_t          cmd,
	output logic                         cmd_ready,
	output logic                         done,
	output logic [7:0]                   rdata,
	output logic                         verify_err,
	output dmcg_pkg::dmcg_reg_req_t      reg_req,
	input  wire logic                    reg_ack,
	input  wire logic [7:0]              reg_rdata
);
	import dmcg_pkg::*;

	// ==========================================================
	// Write-list builder
	typedef enum logic [3:0] {
		S_IDLE  = 4'b0001,
		S_WRITE = 4'b0010,
		S_READ  = 4'b0100,
		S_DONE  = 4'b1000
	} dmcg_state_t;

	dmcg_state_t  state_q;
	dmcg_cmd_t    cmd_q;
	logic [3:0]   idx_q;
	logic [3:0]   last_q;
	logic         rd_only_q;
	logic         seq_ok_q;
	logic [15:0]  step_addr;
	logic [7:0]   step_data;

	// Writes for each step of a command; reads then compare back
	always_comb
	begin
		step_addr = cmd_q.addr;
		step_data = cmd_q.data[7:0];
		case (cmd_q.op)
			DMCG_OP_NORMAL:
			begin
				case (idx_q)
					// [RULE_06] lock monitor running
					4'h0:
					begin
						step_addr = ADDR_LOCKMON_GATE;
						step_data = 8'h00;
					end
					// [RULE_07] absence detectors running
					4'h1:
					begin
						step_addr = ADDR_ABSENCE_GATE;
						step_data = 8'h00;
					end
					// [RULE_08] offset clocks running
					4'h2:
					begin
						step_addr = ADDR_OFFSET_CLK;
						step_data = 8'h00;
					end
					// [RULE_09] offset dividers running
					4'h3:
					begin
						step_addr = ADDR_OFFSET_DIV;
						step_data = 8'h00;
					end
					// [RULE_10] calibration overrides clear
					4'h4:
					begin
						step_addr = ADDR_CALIB_OVR;
						step_data = 8'h00;
					end
					4'h5:
					begin
						// [RULE_11] [RULE_12] [RULE_13] output gate msb set, feedback on
						step_addr = ADDR_DIV_CLK_GATE;
						step_data = 8'h00;
						step_data[OUT_GATE_MSB_BIT] = 1'b1;
						step_data[3:0] = cmd_q.data[3:0];
						step_data[FB_DIV_GATE_BIT] = 1'b0;
						step_data[FB_CAL_INH_BIT] = 1'b0;
					end
					default:
					begin
						// [RULE_03] [RULE_04] [RULE_05] fraction clocks on
						step_addr = ADDR_FRAC_GATE;
						step_data = 8'h00;
					end
				endcase
			end
			DMCG_OP_FRAC:
			begin
				// [RULE_02] [RULE_03] [RULE_04] [RULE_05] clear bit of any fractional divider
				step_addr = ADDR_FRAC_GATE;
				step_data = cmd_q.data[7:0] & MASK_FRAC_ALL & ~cmd_q.data[11:4];
			end
			DMCG_OP_OUTLOOPS:
			begin
				// [RULE_11] top bit forced high
				step_addr = ADDR_DIV_CLK_GATE;
				step_data = (cmd_q.data[7:0] & MASK_DIVGATE) | 8'h10;
			end
			DMCG_OP_VCOCODE:
			begin
				// [RULE_14] low byte first, then upper nibble
				step_addr = (idx_q == 4'h0) ? ADDR_VCO_CODE_LO : ADDR_VCO_CODE_HI;
				step_data = (idx_q == 4'h0) ? cmd_q.data[7:0] : {4'h0, cmd_q.data[11:8]};
			end
			DMCG_OP_UPDATE:
			begin
				// [RULE_15] both reserved registers in turn
				step_addr = (idx_q == 4'h0) ? ADDR_RSVD_UPD_A : ADDR_RSVD_UPD_B;
				step_data = (idx_q == 4'h0) ? cmd_q.data[7:0] : {cmd_q.data[11:8], 4'h0};
			end
			DMCG_OP_AUTOSTOP:
			begin
				// [RULE_01] bit 3 of the chosen output register
				case (cmd_q.data[1:0])
					2'h2: step_addr = ADDR_OUT_DIV2_AUTO;
					2'h3: step_addr = ADDR_OUT_DIV3_AUTO;
					default: step_addr = ADDR_OUT_DIV4_AUTO;
				endcase
				step_data = 8'h00;
				step_data[AUTOSTOP_BIT] = cmd_q.data[4];
			end
			default:
			begin
				step_addr = cmd_q.addr;
				step_data = cmd_q.data[7:0];
			end
		endcase
	end

	function automatic logic [3:0] dmcg_steps(input dmcg_op_t op);
		case (op)
			DMCG_OP_NORMAL:  dmcg_steps = 4'(NUM_NORMAL - 2);
			DMCG_OP_VCOCODE: dmcg_steps = 4'h1;
			DMCG_OP_UPDATE:  dmcg_steps = 4'h1;
			default:         dmcg_steps = 4'h0;
		endcase
	endfunction

	// ==========================================================
	// Sequencer
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_q   <= S_IDLE;
			cmd_q     <= '0;
			idx_q     <= 4'h0;
			last_q    <= 4'h0;
			rd_only_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				S_IDLE:
					if (cmd_valid)
					begin
						cmd_q     <= cmd;
						idx_q     <= 4'h0;
						last_q    <= dmcg_steps(cmd.op);
						rd_only_q <= (cmd.op == DMCG_OP_RAW) && cmd.data[11];
						state_q   <= ((cmd.op == DMCG_OP_RAW) && cmd.data[11]) ? S_READ : S_WRITE;
					end
				S_WRITE:
					if (reg_ack)
						state_q <= S_READ;
				S_READ:
					if (reg_ack)
					begin
						if (idx_q == last_q || rd_only_q)
							state_q <= S_DONE;
						else
						begin
							idx_q   <= idx_q + 4'h1;
							state_q <= S_WRITE;
						end
					end
				S_DONE:
					state_q <= S_IDLE;
				default:
					state_q <= S_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Device register requests, held until acknowledged
	always_ff @(posedge clk)
	begin
		if (rst)
			reg_req <= '0;
		else if (reg_ack)
			reg_req <= '0;
		else if (state_q == S_WRITE)
			reg_req <= '{wr: 1'b1, rd: 1'b0, addr: step_addr, wdata: step_data};
		else if (state_q == S_READ)
			reg_req <= '{wr: 1'b0, rd: 1'b1, addr: step_addr, wdata: 8'h00};
		else
			reg_req <= '0;
	end

	// ==========================================================
	// Readback check: reserved bytes written by update commands are excluded since their meaning is opaque
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rdata      <= 8'h00;
			seq_ok_q   <= 1'b1;
			verify_err <= 1'b0;
		end
		else if (state_q == S_IDLE && cmd_valid)
			seq_ok_q <= 1'b1;
		else if (state_q == S_READ && reg_ack)
		begin
			rdata <= reg_rdata;
			// [RULE_16] last write must read back
			if (!rd_only_q && cmd_q.op != DMCG_OP_UPDATE && reg_rdata != step_data)
				seq_ok_q <= 1'b0;
		end
		else if (state_q == S_DONE)
			verify_err <= !seq_ok_q;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cmd_ready <= 1'b0;
			done      <= 1'b0;
		end
		else
		begin
			cmd_ready <= (state_q == S_IDLE) && !cmd_valid;
			done      <= (state_q == S_DONE);
		end
	end

	// ==========================================================
	// Checks
	// [RULE_11] output gate top bit
	out_gate_msb_a: assert property (@(posedge clk) disable iff (rst) // [RULE_11]
		(reg_req.wr && reg_req.addr == ADDR_DIV_CLK_GATE) |-> reg_req.wdata[OUT_GATE_MSB_BIT])
		else $error("output gate msb written low");
	// [RULE_10] calibration overrides zero under normal op
	calib_zero_a: assert property (@(posedge clk) disable iff (rst) // [RULE_10]
		(reg_req.wr && reg_req.addr == ADDR_CALIB_OVR && cmd_q.op == DMCG_OP_NORMAL)
		|-> reg_req.wdata == 8'h00)
		else $error("calibration override not cleared");
	// [RULE_03] fractional dividers never gated
	frac_clear_a: assert property (@(posedge clk) disable iff (rst) // [RULE_03]
		(reg_req.wr && reg_req.addr == ADDR_FRAC_GATE && cmd_q.op == DMCG_OP_FRAC)
		|-> (reg_req.wdata & cmd_q.data[11:4]) == 8'h00)
		else $error("fractional divider left gated");
	// [RULE_14] high code follows low code
	// Window allows a readback wait of up to fifteen cycles
	vco_order_a: assert property (@(posedge clk) disable iff (rst) // [RULE_14]
		(reg_req.wr && reg_req.addr == ADDR_VCO_CODE_LO && reg_ack
			&& cmd_q.op == DMCG_OP_VCOCODE)
		|-> ##[1:20] (reg_req.wr && reg_req.addr == ADDR_VCO_CODE_HI))
		else $error("upper oscillator code not written");
	// [RULE_15] second reserved write follows
	rsvd_pair_a: assert property (@(posedge clk) disable iff (rst) // [RULE_15]
		(reg_req.wr && reg_req.addr == ADDR_RSVD_UPD_A && reg_ack
			&& cmd_q.op == DMCG_OP_UPDATE)
		|-> ##[1:20] (reg_req.wr && reg_req.addr == ADDR_RSVD_UPD_B))
		else $error("second reserved write missing");
	// [RULE_12] feedback divider enabled
	fb_enable_a: assert property (@(posedge clk) disable iff (rst) // [RULE_12]
		(reg_req.wr && reg_req.addr == ADDR_DIV_CLK_GATE && cmd_q.op == DMCG_OP_NORMAL)
		|-> !reg_req.wdata[FB_DIV_GATE_BIT] && !reg_req.wdata[FB_CAL_INH_BIT])
		else $error("feedback divider left off");
	// [RULE_16] mismatch reported
	verify_flag_a: assert property (@(posedge clk) disable iff (rst) // [RULE_16]
		(state_q == S_DONE && !seq_ok_q) |=> verify_err && done)
		else $error("readback mismatch not flagged");
	// [RULE_01] autostop writes only bit 3
	autostop_bit_a: assert property (@(posedge clk) disable iff (rst) // [RULE_01]
		(reg_req.wr && cmd_q.op == DMCG_OP_AUTOSTOP)
		|-> (reg_req.wdata & ~MASK_AUTOSTOP) == 8'h00)
		else $error("autostop write touches other bits");
	// [RULE_06] lock monitors clocked
	lockmon_run_a: assert property (@(posedge clk) disable iff (rst) // [RULE_06]
		(reg_req.wr && reg_req.addr == ADDR_LOCKMON_GATE && cmd_q.op == DMCG_OP_NORMAL)
		|-> (reg_req.wdata & MASK_LOCKMON) == 8'h00)
		else $error("lock monitor left gated");
	// [RULE_07] absence detectors clocked
	absence_run_a: assert property (@(posedge clk) disable iff (rst) // [RULE_07]
		(reg_req.wr && reg_req.addr == ADDR_ABSENCE_GATE && cmd_q.op == DMCG_OP_NORMAL)
		|-> (reg_req.wdata & MASK_LOW4) == 8'h00)
		else $error("absence detector left gated");
	// [RULE_08] offset clocks running
	offset_clock_a: assert property (@(posedge clk) disable iff (rst) // [RULE_08]
		(reg_req.wr && reg_req.addr == ADDR_OFFSET_CLK && cmd_q.op == DMCG_OP_NORMAL)
		|-> (reg_req.wdata & MASK_OFFSET) == 8'h00)
		else $error("offset monitor clock left gated");
	// [RULE_09] offset dividers running
	offset_divider_a: assert property (@(posedge clk) disable iff (rst) // [RULE_09]
		(reg_req.wr && reg_req.addr == ADDR_OFFSET_DIV && cmd_q.op == DMCG_OP_NORMAL)
		|-> (reg_req.wdata & MASK_OFFSET) == 8'h00)
		else $error("offset monitor divider left gated");
	// [RULE_13] feedback calibration allowed
	fb_calib_a: assert property (@(posedge clk) disable iff (rst) // [RULE_13]
		(reg_req.wr && reg_req.addr == ADDR_DIV_CLK_GATE && cmd_q.op == DMCG_OP_NORMAL)
		|-> !reg_req.wdata[FB_CAL_INH_BIT])
		else $error("feedback calibration left inhibited");
	// [RULE_02] fraction gate field only
	frac_field_a: assert property (@(posedge clk) disable iff (rst) // [RULE_02]
		(reg_req.wr && reg_req.addr == ADDR_FRAC_GATE && cmd_q.op == DMCG_OP_FRAC)
		|-> (reg_req.wdata & ~MASK_FRAC_ALL) == 8'h00)
		else $error("fraction gate write outside its field");
	// [RULE_04] [RULE_05] feedback fractions clocked
	loop_frac_a: assert property (@(posedge clk) disable iff (rst) // [RULE_04]
		(reg_req.wr && reg_req.addr == ADDR_FRAC_GATE && cmd_q.op == DMCG_OP_NORMAL)
		|-> !reg_req.wdata[FB_FRAC_A_BIT] && !reg_req.wdata[FB_FRAC_B_BIT])
		else $error("feedback fraction left gated");
	// [RULE_16] request held until acknowledge
	req_hold_a: assert property (@(posedge clk) disable iff (rst) // [RULE_16]
		((reg_req.wr || reg_req.rd) && !reg_ack)
		|=> $stable(reg_req))
		else $error("register request changed before acknowledge");
	// [RULE_14] upper code only four bits
	vco_nibble_a: assert property (@(posedge clk) disable iff (rst) // [RULE_14]
		(reg_req.wr && reg_req.addr == ADDR_VCO_CODE_HI && cmd_q.op == DMCG_OP_VCOCODE)
		|-> (reg_req.wdata & ~MASK_HI_CODE) == 8'h00)
		else $error("upper oscillator code too wide");
	wr_rd_c: cover property (@(posedge clk) disable iff (rst) reg_req.wr ##[1:8] reg_req.rd);
	normal_c: cover property (@(posedge clk) disable iff (rst)
		done && cmd_q.op == DMCG_OP_NORMAL);
	err_c: cover property (@(posedge clk) disable iff (rst) verify_err);
	vco_c: cover property (@(posedge clk) disable iff (rst)
		done && cmd_q.op == DMCG_OP_VCOCODE);
	update_c: cover property (@(posedge clk) disable iff (rst)
		done && cmd_q.op == DMCG_OP_UPDATE);

endmodule // dmcg_host

// ---- tb/dmcg_dev_model.sv ----
// Behavioural model of the device register bank behind the host controller
`timescale 1ns/10ps
module dmcg_dev_model
	import dmcg_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst,
	input  dmcg_pkg::dmcg_reg_req_t req,
	input  wire logic [3:0]         ack_delay,
	input  wire logic               corrupt,
	output logic                    reg_ack,
	output logic [7:0]              reg_rdata
);
	// ==========================================================
	// Register map
	localparam logic [15:0] MAP_ADDR [14] = '{16'h0a20, 16'h0a26, 16'h0a2c, 16'h0b24,
		16'h0b25, 16'h0b44, 16'h0b45, 16'h0b46, 16'h0b47, 16'h0b48, 16'h0b49, 16'h0b4a,
		16'h0b57, 16'h0b58};
	localparam logic [7:0] MAP_MASK [14] = '{8'h08, 8'h08, 8'h08, 8'hff, 8'hff, 8'h3f,
		8'h03, 8'h0f, 8'h13, 8'h13, 8'h0f, 8'h7f, 8'hff, 8'h0f};
	logic [7:0] mem_q [14];
	logic [3:0] wait_q;
	int         hit;

	always_comb
	begin
		hit = -1;
		for (int i = 0; i < 14; i++)
			if (MAP_ADDR[i] === req.addr)
				hit = i;
	end

	// ==========================================================
	// Access engine; read data scrambles when not valid
	// Read returns written
	always_ff @(posedge clk)
	begin
		reg_ack   <= 1'b0;
		reg_rdata <= ~reg_rdata;
		if (rst)
		begin
			wait_q    <= 4'h0;
			reg_rdata <= 8'h00;
			for (int i = 0; i < 14; i++)
				mem_q[i] <= 8'h00;
		end
		else if ((req.wr || req.rd) && !reg_ack)
		begin
			if (wait_q != ack_delay)
				wait_q <= wait_q + 4'h1;
			else
			begin
				wait_q  <= 4'h0;
				reg_ack <= 1'b1;
				if (req.wr && hit >= 0)
					mem_q[hit] <= req.wdata & MAP_MASK[hit];
				reg_rdata <= ((hit >= 0) ? mem_q[hit] : 8'h00) ^ {7'h00, corrupt};
			end
		end
	end
endmodule // dmcg_dev_model

// ---- tb/divider_monitor_clock_gating_regs_test.sv ----
// Self-checking testbench for the gating-bank host controller
`timescale 1ns/10ps
module divider_monitor_clock_gating_regs_test;
	import dmcg_pkg::*;
	logic          clk, rst, cmd_valid, cmd_ready, done, verify_err, reg_ack, corrupt;
	logic [7:0]    rdata, reg_rdata;
	logic [3:0]    ack_delay;
	dmcg_cmd_t     cmd;
	dmcg_reg_req_t reg_req;
	int            n_mismatch, n_tests;
	localparam logic [15:0] T_ADDR [14] = '{16'h0a20, 16'h0a26, 16'h0a2c, 16'h0b24,
		16'h0b25, 16'h0b44, 16'h0b45, 16'h0b46, 16'h0b47, 16'h0b48, 16'h0b49, 16'h0b4a,
		16'h0b57, 16'h0b58};
	localparam logic [7:0] T_MASK [14] = '{8'h08, 8'h08, 8'h08, 8'hff, 8'hff, 8'h3f,
		8'h03, 8'h0f, 8'h13, 8'h13, 8'h0f, 8'h7f, 8'hff, 8'h0f};

	dmcg_host uut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .done(done), .rdata(rdata), .verify_err(verify_err),
		.reg_req(reg_req), .reg_ack(reg_ack), .reg_rdata(reg_rdata));
	dmcg_dev_model dev (.clk(clk), .rst(rst), .req(reg_req), .ack_delay(ack_delay),
		.corrupt(corrupt), .reg_ack(reg_ack), .reg_rdata(reg_rdata));

	// ==========================================================
	// Shared tasks
	task automatic finish_test();
		if (n_mismatch == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Bounded wait so a stuck controller still ends the run
	task automatic run(input dmcg_op_t op, input logic [15:0] a, input logic [11:0] d);
		int k;
		@(posedge clk);
		#1;
		check("cmd ready idle", {7'h00, cmd_ready}, 8'h01);
		cmd_valid = 1'b1;
		cmd = '{op, a, d};
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		check("cmd ready busy", {7'h00, cmd_ready}, 8'h00);
		for (k = 0; k < 500 && done !== 1'b1; k++)
		begin
			@(posedge clk);
			#1;
		end
		if (done !== 1'b1)
		begin
			n_mismatch++;
			finish_test();
		end
		@(posedge clk);
		#1;
		check("done pulse", {7'h00, done}, 8'h00);
	endtask

	task automatic peek(input logic [15:0] a, input logic [7:0] exp);
		run(DMCG_OP_RAW, a, 12'h800);
		check("readback", rdata, exp);
	endtask

	// ==========================================================
	// Scenarios
	task automatic test_access();
		for (int d = 0; d < 6; d += 5)
		begin
			ack_delay = 4'(d);
			for (int i = 0; i < 14; i++)
			begin
				run(DMCG_OP_RAW, T_ADDR[i], {4'h0, T_MASK[i]});
				check("raw rdata", rdata, T_MASK[i]);
				check("raw verify", {7'h00, verify_err}, 8'h00);
			end
		end
		peek(16'h0b4b, 8'h00);
	endtask

	task automatic test_normal();
		run(DMCG_OP_RAW, 16'h0b4a, 12'h07f);
		run(DMCG_OP_RAW, 16'h0b47, 12'h013);
		run(DMCG_OP_NORMAL, 16'h0000, 12'h005);
		for (int i = 5; i < 11; i++)
			peek(T_ADDR[i], 8'h00);
		peek(16'h0b4a, 8'h15);
	endtask

	task automatic test_fields();
		run(DMCG_OP_FRAC, 16'h0000, 12'h05f);
		peek(16'h0b44, 8'h1a);
		run(DMCG_OP_FRAC, 16'h0000, 12'h33f);
		peek(16'h0b44, 8'h0c);
		run(DMCG_OP_OUTLOOPS, 16'h0000, 12'h0ea);
		peek(16'h0b4a, 8'h7a);
		run(DMCG_OP_VCOCODE, 16'h0000, 12'habc);
		peek(16'h0b57, 8'hbc);
		peek(16'h0b58, 8'h0a);
		run(DMCG_OP_UPDATE, 16'h0000, 12'h5a3);
		peek(16'h0b24, 8'ha3);
		peek(16'h0b25, 8'h50);
	endtask

	task automatic test_autostop();
		for (int s = 0; s < 3; s++)
		begin
			run(DMCG_OP_AUTOSTOP, 16'h0000, {7'h00, 1'b1, 2'h0, 2'(s + 2)});
			peek(T_ADDR[(s + 2) % 4 == 0 ? 2 : s], 8'h08);
			run(DMCG_OP_AUTOSTOP, 16'h0000, {7'h00, 1'b0, 2'h0, 2'(s + 2)});
			peek(T_ADDR[(s + 2) % 4 == 0 ? 2 : s], 8'h00);
		end
	endtask

	task automatic test_verify();
		corrupt = 1'b1;
		run(DMCG_OP_RAW, 16'h0b57, 12'h0aa);
		check("verify bad", {7'h00, verify_err}, 8'h01);
		corrupt = 1'b0;
		run(DMCG_OP_RAW, 16'h0b57, 12'h0aa);
		check("verify good", {7'h00, verify_err}, 8'h00);
	endtask

	// ==========================================================
	// Clock and main sequence
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		n_mismatch = 0;
		n_tests = 0;
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd = '{DMCG_OP_RAW, 16'h0000, 12'h000};
		ack_delay = 4'h0;
		corrupt = 1'b0;
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		check("done at reset", {7'h00, done}, 8'h00);
		check("rdata at reset", rdata, 8'h00);
		check("ready at reset", {7'h00, cmd_ready}, 8'h00);
		test_access();
		test_normal();
		test_fields();
		test_autostop();
		test_verify();
		finish_test();
	end
endmodule // divider_monitor_clock_gating_regs_test
